//--- design/gen_seq_consts.vh
// Timing, encoding and field constants for the generator auto-start sequencer
`ifndef GEN_SEQ_CONSTS_VH
`define GEN_SEQ_CONSTS_VH
`define CLK_FREQ_HZ        100000000
`define TICK_PERIOD_S      1
`define TICK_CYCLES        (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define LOW_BATTERY_CUTOUT_HOLD_S        30
`define LOW_BATTERY_CUTOUT_HOLD_W        6
`define MIN_RUN_CLEAR_S    300
`define SEC_PER_MIN        60
`define MIN_PER_DAY        1440
`define COARSE_STEP_MIN    10
`define MAX_ATTEMPTS       6
`define GLOW_STOP_S        16'h0002
`define MODE_GS            2'h0
`define MODE_RN1           2'h1
`define MODE_RN2           2'h2
`define SETW               8
`define SEC_W              16
`define MIN_W              11
`endif

//--- design/generator_autostart_sequencer.v
// Generator auto-start sequencer: start/stop decisions and relay sequencing
`timescale 1ns/100ps
`default_nettype none
`include "gen_seq_consts.vh"

// Behaviour
// - Stop a generator auto-started at run-start time daily at run-stop time, ten-minute steps.
// - In quiet time start only after thirty seconds at or below cutout.
// - Quiet time ignores load, daily-time and slow battery start conditions.
// - Reaching quiet-time begin stops a running generator.
// - Equal quiet begin and end disables quiet time; ten-minute steps.
// - Count idle days; at exercise period start at quiet end for set minutes.
// - Five minutes of running clears the idle-day counter.
// - Exercise period zero disables; one means exercise daily.
// - Cooldown runs the generator unloaded for set minutes before auto stop.
// - Unmonitored mode stops when run time reaches maximum run setting.
// - Sensed modes use AC sense; unmonitored makes one unsensed attempt.
// - Glow-stop relay open while running, pulses to stop and for glow.
// - Run modes hold run relay energized while running, released when off.
// - Crank energizes after pre-crank; releases on AC sense or max crank.
// - Failed sensed start waits post-crank and retries, six attempts total.
// - Glow-stop issues a stop pulse after a failed attempt before recrank.
// - Unmonitored mode cranks full max time once per start.
// - Auto start on quiet end, low battery, load current or run-start time.
// - Auto stop after charging completes.
// - Auto stop when load stays below threshold past stop delay.
// - Manual on starts; manual off stops immediately.
// - Quiet begin stops and blocks battery, load and run-time stop handling.
// - Auto stops other than exercise end and maximum run time stop only after cooldown.
module generator_autostart_sequencer (
  // Clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  // Time of day in minutes since midnight
  input  wire [`MIN_W-1:0] time_of_day_min_i,
  // Configuration, time-of-day and max run settings in ten-minute steps
  input  wire [1:0]       relay_mode_i,
  input  wire [7:0]       run_start_step_i,
  input  wire [7:0]       run_stop_step_i,
  input  wire [7:0]       quiet_begin_step_i,
  input  wire [7:0]       quiet_end_step_i,
  input  wire [7:0]       exercise_period_days_i,
  input  wire [7:0]       exercise_run_minutes_i,
  input  wire [7:0]       cooldown_minutes_i,
  input  wire [7:0]       max_run_time_i,
  input  wire [7:0]       pre_crank_delay_i,
  input  wire [7:0]       max_crank_time_i,
  input  wire [7:0]       post_crank_delay_i,
  // Condition inputs from the charger and meters
  input  wire             low_battery_cutout_i,
  input  wire             batt_24h_start_i,
  input  wire             batt_2h_start_i,
  input  wire             batt_15m_start_i,
  input  wire             load_start_i,
  input  wire             load_stop_i,
  input  wire             charge_done_i,
  // Operator command
  input  wire             manual_on_i,
  input  wire             manual_off_i,
  // Generator pin
  input  wire             generator_ac_sense_input_i,
  // Relay outputs and status
  output reg              run_stop_relay_o,
  output reg              crank_relay_o,
  output wire             gen_running_o,
  output wire             start_failed_o
);

  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_PRE   = 8'h02;
  localparam [7:0] S_CRANK = 8'h04;
  localparam [7:0] S_POST  = 8'h08;
  localparam [7:0] S_RUN   = 8'h10;
  localparam [7:0] S_COOL  = 8'h20;
  localparam [7:0] S_STOP  = 8'h40;
  localparam [7:0] S_FAIL  = 8'h80;

  // Ten-minute setting to minutes of day
  function [`MIN_W-1:0] step_to_min;
    input [7:0]  s;
    reg   [31:0] full;
    begin
      full        = s * `COARSE_STEP_MIN;
      step_to_min = full[`MIN_W-1:0];
    end
  endfunction

  // Setting minutes to seconds
  function [`SEC_W-1:0] min_to_sec;
    input [`MIN_W-1:0] m;
    reg   [31:0]       full;
    begin
      full       = m * `SEC_PER_MIN;
      min_to_sec = full[`SEC_W-1:0];
    end
  endfunction

  reg  [7:0]        state_q;
  reg  [26:0]       tick_cnt_q;
  reg               tick_q;
  reg  [2:0]        ac_sync_q;
  reg               ac_q;
  reg  [`MIN_W-1:0] tod_prev_q;
  reg  [`LOW_BATTERY_CUTOUT_HOLD_W-1:0] low_battery_cutout_cnt_q;
  reg  [`SEC_W-1:0] tmr_q;
  reg  [`SEC_W+1:0] run_sec_q; // Holds the longest run limit
  reg  [7:0]        idle_days_q;
  reg  [2:0]        attempts_q;
  reg               auto_q;
  reg               exercise_q;
  reg               daily_q;

  // One-second tick
  // single timebase
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= 27'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == `TICK_CYCLES - 1) begin
      tick_cnt_q <= 27'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 27'h1;
      tick_q     <= 1'b0;
    end
  end

  // AC sense synchroniser, change accepted when stages two and three agree
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ac_sync_q <= 3'h0;
      ac_q      <= 1'b0;
    end else begin
      ac_sync_q <= {ac_sync_q[1:0], generator_ac_sense_input_i};
      if (ac_sync_q[1] == ac_sync_q[2]) begin
        ac_q <= ac_sync_q[2];
      end
    end
  end

  // Time-of-day events fire once on arrival at a setting
  wire tod_new     = (time_of_day_min_i != tod_prev_q);
  wire at_qbegin   = tod_new && (quiet_begin_step_i != quiet_end_step_i) &&
                     (time_of_day_min_i == step_to_min(quiet_begin_step_i));
  wire at_qend     = tod_new && (time_of_day_min_i == step_to_min(quiet_end_step_i));
  // daily run times in ten-minute steps
  wire at_rstart   = tod_new && (time_of_day_min_i == step_to_min(run_start_step_i));
  wire at_rstop    = tod_new && (time_of_day_min_i == step_to_min(run_stop_step_i));
  wire at_midnight = tod_new && (time_of_day_min_i == {`MIN_W{1'b0}});

  // Quiet window, wraps past midnight
  wire [`MIN_W-1:0] qb = step_to_min(quiet_begin_step_i);
  wire [`MIN_W-1:0] qe = step_to_min(quiet_end_step_i);
  wire quiet = (qb == qe) ? 1'b0 :
               (qb < qe) ? (time_of_day_min_i >= qb && time_of_day_min_i < qe) :
                           (time_of_day_min_i >= qb || time_of_day_min_i < qe);

  wire low_battery_cutout_ok = (low_battery_cutout_cnt_q == `LOW_BATTERY_CUTOUT_HOLD_S);
  // quiet time masks slower start sources
  wire slow_start = batt_24h_start_i || batt_2h_start_i || batt_15m_start_i ||
                    load_start_i || at_rstart;
  wire exer_due = (exercise_period_days_i != 8'h0) &&
                  (idle_days_q >= exercise_period_days_i) && at_qend;
  wire auto_start = low_battery_cutout_ok || (!quiet && (slow_start || (at_qend && qb != qe))) || exer_due;

  wire sensed   = (relay_mode_i != `MODE_RN2);
  wire running  = sensed ? ac_q : (state_q == S_RUN || state_q == S_COOL);
  wire is_gs    = (relay_mode_i == `MODE_GS);

  // Stop conditions while running
  // charge complete stop
  // quiet begin stops, blocks other stop handling
  wire stop_cool = at_qbegin ||
                   (!quiet && auto_q && !exercise_q &&
                    (charge_done_i || load_stop_i || (daily_q && at_rstop)));
  wire [31:0] max_run_s   = max_run_time_i * `COARSE_STEP_MIN * `SEC_PER_MIN;
  wire        max_run_hit = !sensed && ({14'h0, run_sec_q} >= max_run_s);
  // exercise ends after set minutes, no cooldown
  wire exer_end = exercise_q &&
                  (run_sec_q >= {2'h0, min_to_sec({3'h0, exercise_run_minutes_i})});

  // Low-battery hold counter and time-of-day history
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_battery_cutout_cnt_q <= {`LOW_BATTERY_CUTOUT_HOLD_W{1'b0}};
      tod_prev_q <= time_of_day_min_i; // No false arrival after reset
    end else begin
      tod_prev_q <= time_of_day_min_i;
      if (!low_battery_cutout_i) begin
        low_battery_cutout_cnt_q <= {`LOW_BATTERY_CUTOUT_HOLD_W{1'b0}};
      end else if (tick_q && !low_battery_cutout_ok) begin
        low_battery_cutout_cnt_q <= low_battery_cutout_cnt_q + 1'b1;
      end
    end
  end

  // Idle-day counter
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      idle_days_q <= 8'h0;
    // five minutes running clears the count
    end else if (running && run_sec_q >= `MIN_RUN_CLEAR_S) begin
      idle_days_q <= 8'h0;
    end else if (at_midnight && idle_days_q != 8'hff) begin
      idle_days_q <= idle_days_q + 8'h1;
    end
  end

  // Sequencer
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q    <= S_IDLE;
      tmr_q      <= {`SEC_W{1'b0}};
      run_sec_q  <= {(`SEC_W+2){1'b0}};
      attempts_q <= 3'h0;
      auto_q     <= 1'b0;
      exercise_q <= 1'b0;
      daily_q    <= 1'b0;
    end else begin
      if (tick_q && tmr_q != {`SEC_W{1'b0}}) begin
        tmr_q <= tmr_q - 1'b1;
      end
      if (tick_q && (state_q == S_RUN || state_q == S_COOL) && run_sec_q != {(`SEC_W+2){1'b1}}) begin
        run_sec_q <= run_sec_q + 1'b1;
      end
      if (manual_off_i && state_q != S_IDLE && state_q != S_FAIL) begin
        state_q <= S_STOP;
        tmr_q   <= `GLOW_STOP_S;
      end else begin
        case (state_q)
          S_IDLE, S_FAIL: begin
            if (!manual_off_i && (manual_on_i || (auto_start && state_q == S_IDLE))) begin
              state_q    <= S_PRE;
              tmr_q      <= {8'h0, pre_crank_delay_i};
              attempts_q <= 3'h1;
              run_sec_q  <= {(`SEC_W+2){1'b0}};
              auto_q     <= !manual_on_i;
              exercise_q <= !manual_on_i && exer_due && !low_battery_cutout_ok;
              daily_q    <= !manual_on_i && at_rstart;
            end
          end
          S_PRE: begin
            if (tmr_q == {`SEC_W{1'b0}}) begin
              state_q <= S_CRANK;
              tmr_q   <= {8'h0, max_crank_time_i};
            end
          end
          S_CRANK: begin
            // sensed modes see AC, unmonitored cranks blind
            if (sensed && ac_q) begin
              state_q <= S_RUN;
            end else if (tmr_q == {`SEC_W{1'b0}}) begin
              if (!sensed) begin
                state_q <= S_RUN;
              end else if (attempts_q == `MAX_ATTEMPTS) begin
                state_q <= S_FAIL;
              end else begin
                state_q <= S_POST;
                tmr_q   <= {8'h0, post_crank_delay_i};
              end
            end
          end
          S_POST: begin
            if (sensed && ac_q) begin
              state_q <= S_RUN;
            end else if (tmr_q == {`SEC_W{1'b0}}) begin
              state_q    <= S_PRE;
              tmr_q      <= {8'h0, pre_crank_delay_i};
              attempts_q <= attempts_q + 3'h1;
            end
          end
          S_RUN: begin
            if (sensed && !ac_q) begin
              state_q <= S_IDLE;
            end else if (exer_end || max_run_hit) begin
              state_q <= S_STOP;
              tmr_q   <= `GLOW_STOP_S;
            end else if (stop_cool) begin
              state_q <= S_COOL;
              tmr_q   <= min_to_sec({3'h0, cooldown_minutes_i});
            end
          end
          S_COOL: begin
            if (tmr_q == {`SEC_W{1'b0}}) begin
              state_q <= S_STOP;
              tmr_q   <= `GLOW_STOP_S;
            end
          end
          S_STOP: begin
            if (tmr_q == {`SEC_W{1'b0}}) begin
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Relay drive from state and mode
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      run_stop_relay_o <= 1'b0;
      crank_relay_o    <= 1'b0;
    end else begin
      // glow-stop pulses for glow and stop
      if (is_gs) begin
        run_stop_relay_o <= (state_q == S_PRE) || (state_q == S_STOP) || (state_q == S_POST);
      end else begin
        run_stop_relay_o <= (state_q == S_PRE) || (state_q == S_CRANK) ||
                            (state_q == S_RUN) || (state_q == S_COOL) || (state_q == S_POST);
      end
      // crank released on AC or time out
      crank_relay_o <= (state_q == S_CRANK) && !(sensed && ac_q) && (tmr_q != {`SEC_W{1'b0}});
    end
  end

  assign gen_running_o  = (state_q == S_RUN) || (state_q == S_COOL);
  assign start_failed_o = (state_q == S_FAIL);

endmodule
`default_nettype wire

//--- verif/gen_model.sv
// Behavioural generator with starter and AC sense output
`timescale 1ns/100ps
`default_nettype none
module gen_model #(
  parameter int CRANK_NEED = 50
) (
  // Clock
  input wire logic ref_clk_i,
  // Relay contacts and AC sense line
  input wire logic crank_i,
  input wire logic run_i,
  input wire logic run_mode_i,
  output var logic ac_o
);
  // ****
  // Engine state
  // ****
  int spin_q;
  initial ac_o = 1'b0;
  // Engine catches after enough cranking, dies on stop or lost run
  always @(posedge ref_clk_i) begin
    spin_q <= crank_i ? spin_q + 1 : 0;
    if (crank_i && spin_q >= CRANK_NEED)
      ac_o <= 1'b1;
    else if (run_mode_i ? !run_i : run_i && !crank_i)
      ac_o <= 1'b0;
  end
endmodule
`default_nettype wire

//--- verif/gen_seq_sva.sv
// Port assertions for the generator auto-start sequencer
`timescale 1ns/100ps
`default_nettype none
`include "gen_seq_consts.vh"
module gen_seq_sva (
  // Clock, reset and controls
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic [1:0] relay_mode_i,
  input wire logic [7:0] pre_crank_delay_i,
  input wire logic       manual_on_i,
  input wire logic       manual_off_i,
  input wire logic       generator_ac_sense_input_i,
  // Outputs
  input wire logic       run_stop_relay_o,
  input wire logic       crank_relay_o,
  input wire logic       gen_running_o,
  input wire logic       start_failed_o
);
  // ****
  // Idle tracking and assertions
  // ****
  logic fresh_q;
  logic fresh_d;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Idle since reset until a relay first moves
  assign fresh_d = fresh_q && !run_stop_relay_o && !crank_relay_o;
  always @(posedge ref_clk_i) begin
    fresh_q <= rst_n_i ? fresh_d : 1'b1;
  end
  a_reset_relays_off: assert property ($rose(rst_n_i) |-> !run_stop_relay_o && !crank_relay_o)
    else $error("relay active after reset");
  a_manual_on_start: assert property (manual_on_i && !manual_off_i && fresh_q |-> ##2 run_stop_relay_o)
    else $error("manual start did not close run relay");
  a_off_stops_run: assert property (manual_off_i |-> ##2 !gen_running_o)
    else $error("manual stop left generator running");
  a_off_stops_crank: assert property (manual_off_i |-> ##2 !crank_relay_o)
    else $error("manual stop left crank active");
  a_run_off_release: assert property (manual_off_i && relay_mode_i inside {2'h1, 2'h2}
    |-> ##2 !run_stop_relay_o)
    else $error("run relay held after stop");
  a_pre_crank_wait: assert property ($rose(run_stop_relay_o) && pre_crank_delay_i > 8'h01
    |-> !crank_relay_o [*8])
    else $error("crank before pre-crank delay");
  a_rn1_crank_run: assert property (crank_relay_o && relay_mode_i == `MODE_RN1 |-> run_stop_relay_o)
    else $error("crank without run relay");
  a_gs_run_open: assert property (relay_mode_i == `MODE_GS && gen_running_o && $past(gen_running_o)
    |-> !run_stop_relay_o)
    else $error("glow-stop relay closed while running");
  a_run_mode_hold: assert property (relay_mode_i inside {2'h1, 2'h2} && gen_running_o && $past(gen_running_o)
    |-> run_stop_relay_o)
    else $error("run relay open while running");
  a_crank_ac_drop: assert property ((crank_relay_o && relay_mode_i != `MODE_RN2 && generator_ac_sense_input_i) [*4]
    |-> ##[1:4] !crank_relay_o)
    else $error("crank held after AC sensed");
  a_failed_quiet: assert property (start_failed_o |-> !crank_relay_o && !gen_running_o)
    else $error("activity after failed start");
  // Main scenarios reached
  cover property (manual_on_i && fresh_q);
  cover property ($fell(run_stop_relay_o));
  cover property ($rose(run_stop_relay_o) && relay_mode_i == `MODE_GS);
  cover property ($rose(start_failed_o));
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the generator auto-start sequencer
`timescale 1ns/100ps
`default_nettype none
`include "gen_seq_consts.vh"
module testbench;
  // ****
  // Signals, instances and clock
  // ****
  logic              ref_clk_i, rst_n_i, manual_on_i, manual_off_i, load_start_i, load_stop_i, charge_done_i;
  logic              batt_24h_start_i, batt_2h_start_i, batt_15m_start_i, low_battery_cutout_i;
  logic [1:0]        relay_mode_i;
  logic [`MIN_W-1:0] time_of_day_min_i;
  logic [7:0]        run_start_step_i, run_stop_step_i, quiet_begin_step_i, quiet_end_step_i;
  logic [7:0]        exercise_period_days_i, exercise_run_minutes_i, cooldown_minutes_i, max_run_time_i;
  logic [7:0]        pre_crank_delay_i, max_crank_time_i, post_crank_delay_i;
  wire               generator_ac_sense_input_i, run_stop_relay_o, crank_relay_o, gen_running_o, start_failed_o;
  int                n_mismatch, n_checks;
  generator_autostart_sequencer generator_autostart_sequencer_i (.ref_clk_i, .rst_n_i, .time_of_day_min_i,
    .relay_mode_i, .run_start_step_i, .run_stop_step_i, .quiet_begin_step_i, .quiet_end_step_i,
    .exercise_period_days_i, .exercise_run_minutes_i, .cooldown_minutes_i, .max_run_time_i,
    .pre_crank_delay_i, .max_crank_time_i, .post_crank_delay_i, .low_battery_cutout_i, .batt_24h_start_i,
    .batt_2h_start_i, .batt_15m_start_i, .load_start_i, .load_stop_i, .charge_done_i, .manual_on_i,
    .manual_off_i, .generator_ac_sense_input_i, .run_stop_relay_o, .crank_relay_o, .gen_running_o,
    .start_failed_o);
  gen_model gen_model_i (.ref_clk_i, .crank_i(crank_relay_o), .run_i(run_stop_relay_o),
    .run_mode_i(relay_mode_i != `MODE_GS), .ac_o(generator_ac_sense_input_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ****
  // Shared tasks
  // ****
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Bounded wait for the run relay, giving up ends the run
  task automatic wait_relay(input logic exp);
    for (int i = 0; i < 8 && run_stop_relay_o !== exp; i++) cyc(1);
    check("run_stop_relay_o", run_stop_relay_o, exp);
    if (run_stop_relay_o !== exp) report_and_stop();
  endtask
  // Bounded wait for the generator to be judged running
  task automatic wait_run;
    for (int i = 0; i < 100 && gen_running_o !== 1'b1; i++) cyc(1);
    check("gen_running_o", gen_running_o, 1'b1);
    if (gen_running_o !== 1'b1) report_and_stop();
  endtask
  task automatic do_reset(input logic [1:0] mode);
    rst_n_i = 1'b0;
    relay_mode_i = mode;
    {manual_on_i, manual_off_i, load_start_i, load_stop_i, charge_done_i} = '0;
    {batt_24h_start_i, batt_2h_start_i, batt_15m_start_i, low_battery_cutout_i} = '0;
    cyc(6);
    rst_n_i = 1'b1;
    cyc(1);
    check("relays after reset", {run_stop_relay_o, crank_relay_o}, 2'b00);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_manual(input logic [1:0] mode);
    do_reset(mode);
    manual_on_i = 1'b1;
    cyc(1);
    manual_on_i = 1'b0;
    wait_relay(1'b1);
    cyc(20);
    check("crank_relay_o", crank_relay_o, 1'b0);
    manual_off_i = 1'b1;
    cyc(4);
    check("gen_running_o", gen_running_o, 1'b0);
    if (mode != `MODE_GS) check("run_stop_relay_o", run_stop_relay_o, 1'b0);
    manual_off_i = 1'b0;
    cyc(1);
  endtask
  task automatic t_daily;
    do_reset(`MODE_RN2);
    run_start_step_i = 8'h3c;
    time_of_day_min_i = 11'h257;
    cyc(10);
    check("run_stop_relay_o", run_stop_relay_o, 1'b0);
    time_of_day_min_i = 11'h258;
    wait_relay(1'b1);
  endtask
  // Quiet window wraps midnight, start causes held off until disabled
  task automatic t_quiet;
    do_reset(`MODE_RN1);
    quiet_begin_step_i = 8'h84;
    quiet_end_step_i = 8'h24;
    run_start_step_i = 8'h8a;
    time_of_day_min_i = 11'h55a;
    cyc(2);
    time_of_day_min_i = 11'h564;
    for (int k = 0; k < 5; k++) begin
      {load_start_i, batt_24h_start_i, batt_2h_start_i, batt_15m_start_i, low_battery_cutout_i} = 5'h10 >> k;
      cyc(10);
      check("run_stop_relay_o", run_stop_relay_o, 1'b0);
    end
    low_battery_cutout_i = 1'b0;
    batt_15m_start_i = 1'b1;
    quiet_end_step_i = quiet_begin_step_i;
    wait_relay(1'b1);
  endtask
  // Zero pre-crank: crank until AC, or blind crank when unmonitored, then manual stop
  task automatic t_crank(input logic [1:0] mode);
    do_reset(mode);
    {pre_crank_delay_i, max_crank_time_i, post_crank_delay_i} = 24'h000605;
    manual_on_i = 1'b1;
    cyc(1);
    manual_on_i = 1'b0;
    cyc(2);
    check("crank_relay_o", crank_relay_o, 1'b1);
    if (mode == `MODE_RN2) begin
      cyc(100);
      check("crank_relay_o", crank_relay_o, 1'b1);
      check("gen_running_o", gen_running_o, 1'b0);
    end else begin
      wait_run();
      check("crank_relay_o", crank_relay_o, 1'b0);
      cyc(2);
      check("run_stop_relay_o", run_stop_relay_o, mode != `MODE_GS);
    end
    manual_off_i = 1'b1;
    cyc(3);
    check("gen_running_o", gen_running_o, 1'b0);
    check("run_stop_relay_o", run_stop_relay_o, mode == `MODE_GS);
    check("crank_relay_o", crank_relay_o, 1'b0);
    manual_off_i = 1'b0;
    cyc(1);
  endtask
  // Zero timers: six attempts, three cycles each but two for the last, then failure
  task automatic t_fail;
    do_reset(`MODE_RN1);
    {pre_crank_delay_i, max_crank_time_i, post_crank_delay_i} = 24'h000000;
    manual_on_i = 1'b1;
    cyc(1);
    manual_on_i = 1'b0;
    cyc(16);
    check("start_failed_o", start_failed_o, 1'b0);
    cyc(1);
    check("start_failed_o", start_failed_o, 1'b1);
    check("crank_relay_o", crank_relay_o, 1'b0);
  endtask
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    time_of_day_min_i = 11'h12c;
    {run_start_step_i, run_stop_step_i, quiet_begin_step_i, quiet_end_step_i} = '0;
    {exercise_period_days_i, exercise_run_minutes_i, cooldown_minutes_i, max_run_time_i} = 32'h00050206;
    {pre_crank_delay_i, max_crank_time_i, post_crank_delay_i} = 24'h040605;
    t_manual(`MODE_GS);
    t_manual(`MODE_RN1);
    t_manual(`MODE_RN2);
    t_daily;
    t_quiet;
    t_crank(`MODE_GS);
    t_crank(`MODE_RN1);
    t_crank(`MODE_RN2);
    t_fail;
    report_and_stop();
  end
endmodule
bind generator_autostart_sequencer gen_seq_sva gen_seq_sva_i (.ref_clk_i, .rst_n_i, .relay_mode_i,
  .pre_crank_delay_i, .manual_on_i, .manual_off_i, .generator_ac_sense_input_i, .run_stop_relay_o,
  .crank_relay_o, .gen_running_o, .start_failed_o);
`default_nettype wire
